// ==== logic/rmsr_ctrl.sv ====
// reset mode and software reset controller
`timescale 1ns/1ps
`include "rmsr_map.svh"

module rmsr_ctrl #(
    parameter int SWRST_CYCLES = `RMSR_SWRESET_NS / `RMSR_CLK_PERIOD_NS,
    parameter int WORD_W       = `RMSR_WORD_BITS
) (
    input  wire logic       mclk_i,        // system clock, 40 MHz
    input  wire logic       rst_n_i,       // synchronous reset, active low
    input  wire logic       sck_i,         // serial control clock
    input  wire logic       sdi_i,         // serial control data
    input  wire logic       sel_n_i,       // serial control select, active low
    input  wire logic       rise_fast_i,   // supply rising faster than ramp rate
    input  wire logic       ramp_gap_i,    // supply above ramp by the gap threshold
    input  wire logic       below_sens_i,  // supply below the sensitive low level
    input  wire logic       below_norm_i,  // supply below the normal low level
    output logic            reset_n_o,     // chip reset, active low
    output logic            cfg_init_o,    // one-cycle pulse per event, held high throughout system reset, reload configuration
    output logic            sensitive_o,   // 1 sensitive mode, 0 normal mode
    output logic [1:0]      cause_o        // cause of the latest reset event
);

    localparam int CNT_W = $clog2(SWRST_CYCLES + 1);

    rmsr_pkg::rmsr_state_e state;
    rmsr_pkg::rmsr_state_e next_state;
    logic [CNT_W-1:0]      cnt;
    logic [CNT_W-1:0]      next_cnt;
    logic                  next_sensitive;
    logic                  next_reset_n;
    logic                  next_cfg_init;
    logic [1:0]            next_cause;

    logic                  word_valid;
    logic [WORD_W-1:0]     word;
    logic                  busy;
    logic                  glitch_trip;
    logic                  low_trip;
    logic                  supply_trip;
    rmsr_pkg::rmsr_cmd_e   cmd;

    function automatic rmsr_pkg::rmsr_cmd_e decode_word(input logic [WORD_W-1:0] w);
        if (w == `RMSR_CMD_NORMAL) begin
            decode_word = rmsr_pkg::RMSR_CMD_NORMAL;
        end else if (w == `RMSR_CMD_SENSITIVE) begin
            decode_word = rmsr_pkg::RMSR_CMD_SENS;
        end else if (w == `RMSR_CMD_SWRESET) begin
            decode_word = rmsr_pkg::RMSR_CMD_SWRST;
        end else begin
            decode_word = rmsr_pkg::RMSR_CMD_NONE;
        end
    endfunction : decode_word

    // the receiver is held off for the whole reset event
    assign busy = (state != rmsr_pkg::RMSR_ST_RUN);

    rmsr_word_rx #(
        .WORD_W (WORD_W)
    ) i_rmsr_word_rx (
        .mclk_i       (mclk_i),
        .rst_n_i      (rst_n_i),
        .block_i      (busy),
        .sck_i        (sck_i),
        .sdi_i        (sdi_i),
        .sel_n_i      (sel_n_i),
        .word_valid_o (word_valid),
        .word_o       (word)
    );

    // a word seen in the cycle the event begins is dropped as well
    assign cmd = (word_valid && !busy) ? decode_word(word) : rmsr_pkg::RMSR_CMD_NONE;

    assign glitch_trip = sensitive_o && rise_fast_i && ramp_gap_i;
    assign low_trip    = sensitive_o ? below_sens_i : below_norm_i;
    assign supply_trip = glitch_trip || low_trip;

    always_comb begin
        next_state     = state;
        next_cnt       = cnt;
        next_sensitive = sensitive_o;
        next_cfg_init  = 1'b0;
        next_cause     = cause_o;
        case (state)
            rmsr_pkg::RMSR_ST_RUN: begin
                if (supply_trip) begin
                    next_state    = rmsr_pkg::RMSR_ST_SUPPLY;
                    next_cfg_init = 1'b1;
                    next_cause    = 2'(rmsr_pkg::RMSR_CAUSE_SUPPLY);
                end else begin
                    case (cmd)
                        rmsr_pkg::RMSR_CMD_NORMAL: begin
                            next_sensitive = 1'b0;
                        end
                        rmsr_pkg::RMSR_CMD_SENS: begin
                            next_sensitive = 1'b1;
                        end
                        rmsr_pkg::RMSR_CMD_SWRST: begin
                            // normal mode swallows the request
                            if (sensitive_o) begin
                                next_state    = rmsr_pkg::RMSR_ST_SOFT;
                                next_cnt      = CNT_W'(SWRST_CYCLES - 1);
                                next_cfg_init = 1'b1;
                                next_cause    = 2'(rmsr_pkg::RMSR_CAUSE_SOFT);
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            rmsr_pkg::RMSR_ST_SUPPLY: begin
                // held for as long as the detectors report a bad supply
                if (!supply_trip) begin
                    next_state = rmsr_pkg::RMSR_ST_RUN;
                end
            end
            rmsr_pkg::RMSR_ST_SOFT: begin
                if (supply_trip) begin
                    next_state = rmsr_pkg::RMSR_ST_SUPPLY;
                    next_cause = 2'(rmsr_pkg::RMSR_CAUSE_SUPPLY);
                end else if (cnt == '0) begin
                    next_state = rmsr_pkg::RMSR_ST_RUN;
                end else begin
                    next_cnt = cnt - CNT_W'(1);
                end
            end
            default: begin
                next_state = rmsr_pkg::RMSR_ST_SUPPLY;
            end
        endcase
        // any reset event reloads the mode to its default
        if (next_state != rmsr_pkg::RMSR_ST_RUN) begin
            next_sensitive = `RMSR_SENSITIVE_RST;
        end
        next_reset_n = (next_state == rmsr_pkg::RMSR_ST_RUN);
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            // system reset is itself a reset event, so the pin stays low
            state       <= rmsr_pkg::RMSR_ST_SUPPLY;
            cnt         <= '0;
            sensitive_o <= `RMSR_SENSITIVE_RST;
            reset_n_o   <= 1'b0;
            cfg_init_o  <= 1'b1;
            cause_o     <= 2'(rmsr_pkg::RMSR_CAUSE_SUPPLY);
        end else begin
            state       <= next_state;
            cnt         <= next_cnt;
            sensitive_o <= next_sensitive;
            reset_n_o   <= next_reset_n;
            cfg_init_o  <= next_cfg_init;
            cause_o     <= next_cause;
        end
    end

    // helper: length of the running software reset
    logic [CNT_W-1:0] soft_len;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            soft_len <= '0;
        end else if (state == rmsr_pkg::RMSR_ST_SOFT) begin
            soft_len <= soft_len + CNT_W'(1);
        end else begin
            soft_len <= '0;
        end
    end

    sequence seq_run_word(logic [WORD_W-1:0] w);
        reset_n_o && state == rmsr_pkg::RMSR_ST_RUN && word_valid && word == w
            && !supply_trip;
    endsequence

    sequence seq_soft_entry;
        !reset_n_o && state == rmsr_pkg::RMSR_ST_SOFT && cfg_init_o && sensitive_o;
    endsequence

    sequence seq_event_start;
        !reset_n_o && cfg_init_o && sensitive_o;
    endsequence

    a_start_sensitive: assert property (
        @(posedge mclk_i)
        !rst_n_i |=> sensitive_o && !reset_n_o)
        else $error("mode not sensitive after system reset");

    a_mode_to_normal: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        seq_run_word(`RMSR_CMD_NORMAL) |=> !sensitive_o && reset_n_o)
        else $error("normal mode word did not select normal mode");

    a_mode_to_sens: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        seq_run_word(`RMSR_CMD_SENSITIVE) |=> sensitive_o && reset_n_o)
        else $error("sensitive mode word did not select sensitive mode");

    a_swrst_start: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        seq_run_word(`RMSR_CMD_SWRESET) ##0 sensitive_o |=> seq_soft_entry)
        else $error("software reset word did not start a reset");

    a_swrst_ignored: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        seq_run_word(`RMSR_CMD_SWRESET) ##0 !sensitive_o |=> reset_n_o && !sensitive_o)
        else $error("software reset honoured in normal mode");

    a_swrst_length: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        state == rmsr_pkg::RMSR_ST_SOFT && cnt == '0 && !supply_trip
            |-> soft_len == CNT_W'(SWRST_CYCLES - 1) ##1 reset_n_o)
        else $error("software reset length wrong");

    a_glitch_masked: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        reset_n_o && !sensitive_o && rise_fast_i && ramp_gap_i && !below_norm_i
            |=> reset_n_o)
        else $error("glitch caused reset in normal mode");

    a_glitch_trip: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        sensitive_o && rise_fast_i && ramp_gap_i |=> !reset_n_o && sensitive_o)
        else $error("glitch missed in sensitive mode");

    a_low_trip: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        (sensitive_o ? below_sens_i : below_norm_i) |=> !reset_n_o)
        else $error("low supply did not reset");

    a_low_normal_ok: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        reset_n_o && !sensitive_o && below_sens_i && !below_norm_i && !word_valid
            |=> reset_n_o && !sensitive_o)
        else $error("normal mode reset above its low level");

    a_event_reinit: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        $fell(reset_n_o) |-> cfg_init_o && sensitive_o ##1 !cfg_init_o)
        else $error("reset event did not reload configuration");

    a_busy_ignore: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        !reset_n_o && word_valid |=> sensitive_o && $stable(cause_o) || cfg_init_o)
        else $error("word acted upon during a reset event");

    // the reload pulse must only appear as an event begins
    a_init_in_event: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        cfg_init_o |-> seq_event_start)
        else $error("reload pulse outside a reset event");

    a_init_single: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        cfg_init_o |=> !cfg_init_o)
        else $error("reload pulse longer than one cycle");

    a_event_cause: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        seq_event_start |-> cause_o != 2'(rmsr_pkg::RMSR_CAUSE_NONE))
        else $error("reset event started without a cause");

    a_event_sensitive: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        !reset_n_o |-> sensitive_o)
        else $error("normal mode kept during a reset event");

    // only a control word or a reset event may move the mode
    a_mode_only_cmd: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        reset_n_o && !word_valid |=> $stable(sensitive_o) || !reset_n_o)
        else $error("mode changed without a control word");

    // the receiver itself is blocked, not only the decoder
    a_busy_no_word: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        busy |=> !word_valid)
        else $error("word completed during a reset event");

    a_soft_cause: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        seq_soft_entry |-> cause_o == 2'(rmsr_pkg::RMSR_CAUSE_SOFT))
        else $error("software reset reported with wrong cause");

    // a bad supply outranks the software reset and keeps the chip down
    a_soft_to_supply: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        state == rmsr_pkg::RMSR_ST_SOFT && supply_trip
            |=> state == rmsr_pkg::RMSR_ST_SUPPLY && !reset_n_o
            && cause_o == 2'(rmsr_pkg::RMSR_CAUSE_SUPPLY))
        else $error("supply trip lost during software reset");

    a_supply_release: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        state == rmsr_pkg::RMSR_ST_SUPPLY && !supply_trip |=> reset_n_o)
        else $error("supply reset held after the trip cleared");

endmodule : rmsr_ctrl

// ==== logic/rmsr_map.svh ====
// constants of the reset mode and software reset controller
`ifndef RMSR_MAP_SVH
`define RMSR_MAP_SVH

// serial control words, sixteen bits, first bit received is bit 15
`define RMSR_WORD_BITS       16
`define RMSR_CMD_NORMAL      16'hd540
`define RMSR_CMD_SENSITIVE   16'hd500
`define RMSR_CMD_SWRESET     16'hff00

// analog trip points, carried for reference by the detector flags
`define RMSR_RAMP_MV_PER_MS  100
`define RMSR_RAMP_GAP_MV     600
`define RMSR_LOW_NORMAL_MV   250
`define RMSR_LOW_SENS_MV     1600

// reset defaults
`define RMSR_SENSITIVE_RST   1'b1

// timing
`define RMSR_CLK_PERIOD_NS   25
`define RMSR_SWRESET_NS      250000

`endif

// ==== logic/rmsr_pkg.sv ====
// types of the reset mode and software reset controller
package rmsr_pkg;

    typedef enum logic [1:0] {
        RMSR_ST_RUN,
        RMSR_ST_SUPPLY,
        RMSR_ST_SOFT
    } rmsr_state_e;

    typedef enum logic [1:0] {
        RMSR_CMD_NONE,
        RMSR_CMD_NORMAL,
        RMSR_CMD_SENS,
        RMSR_CMD_SWRST
    } rmsr_cmd_e;

    typedef enum logic [1:0] {
        RMSR_CAUSE_NONE,
        RMSR_CAUSE_SUPPLY,
        RMSR_CAUSE_SOFT
    } rmsr_cause_e;

endpackage : rmsr_pkg

// ==== logic/rmsr_word_rx.sv ====
// serial control word receiver: collects whole sixteen-bit words
`timescale 1ns/1ps
`include "rmsr_map.svh"

module rmsr_word_rx #(
    parameter int WORD_W = `RMSR_WORD_BITS
) (
    input  wire logic              mclk_i,        // system clock
    input  wire logic              rst_n_i,       // synchronous reset, active low
    input  wire logic              block_i,       // drop words while high
    input  wire logic              sck_i,         // serial clock
    input  wire logic              sdi_i,         // serial data
    input  wire logic              sel_n_i,       // select, active low
    output logic                   word_valid_o,  // one-cycle pulse, word complete
    output logic [WORD_W-1:0]      word_o         // last complete word
);

    localparam int CNT_W = $clog2(WORD_W + 1);

    logic              sck_q;
    logic [CNT_W-1:0]  bit_cnt;
    logic [WORD_W-1:0] shift;
    logic              next_sck_q;
    logic [CNT_W-1:0]  next_bit_cnt;
    logic [WORD_W-1:0] next_shift;
    logic              next_word_valid;
    logic [WORD_W-1:0] next_word;
    logic              sck_rise;

    assign sck_rise = sck_i && !sck_q;

    always_comb begin
        next_sck_q      = sck_i;
        next_bit_cnt    = bit_cnt;
        next_shift      = shift;
        next_word_valid = 1'b0;
        next_word       = word_o;
        // a deselect or a reset event discards a partial word
        if (sel_n_i || block_i) begin
            next_bit_cnt = '0;
        end else if (sck_rise && bit_cnt < CNT_W'(WORD_W)) begin
            next_shift   = {shift[WORD_W-2:0], sdi_i};
            next_bit_cnt = bit_cnt + CNT_W'(1);
            if (bit_cnt == CNT_W'(WORD_W - 1)) begin
                next_word_valid = 1'b1;
                next_word       = {shift[WORD_W-2:0], sdi_i};
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            sck_q        <= 1'b0;
            bit_cnt      <= '0;
            shift        <= '0;
            word_valid_o <= 1'b0;
            word_o       <= '0;
        end else begin
            sck_q        <= next_sck_q;
            bit_cnt      <= next_bit_cnt;
            shift        <= next_shift;
            word_valid_o <= next_word_valid;
            word_o       <= next_word;
        end
    end

    a_word_whole: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        word_valid_o |-> $past(bit_cnt) == CNT_W'(WORD_W - 1) && $past(sck_rise)
            && !$past(sel_n_i) && !$past(block_i))
        else $error("word reported before sixteen bits were taken");

endmodule : rmsr_word_rx

// ==== verif/rmsr_host_model.sv ====
// host side model: sends serial control words to the controller
`timescale 1ns/1ps

module rmsr_host_model (
    input  wire logic mclk_i,     // system clock
    input  wire logic reset_n_i,  // device reset, active low
    output logic      sck_o,      // serial clock, still outside frames
    output logic      sdi_o,      // serial data
    output logic      sel_n_o     // select, active low
);
    initial begin
        sck_o   = 1'b0;
        sdi_o   = 1'b1;
        sel_n_o = 1'b1;
    end

    // nbits below 16 aborts a word; rude skips the wait for reset end
    task automatic send(input logic [15:0] w, input int nbits, input int half, input bit rude);
        int i;
        int k;
        if (!rude) begin
            while (reset_n_i !== 1'b1) @(negedge mclk_i);
        end
        @(negedge mclk_i);
        sel_n_o = 1'b0;
        for (i = 15; i > 15 - nbits; i--) begin
            sdi_o = w[i];
            sck_o = 1'b0;
            for (k = 0; k < half; k++) @(negedge mclk_i);
            sck_o = 1'b1;
            for (k = 0; k < half; k++) @(negedge mclk_i);
        end
        sck_o = 1'b0;
        for (k = 0; k < half; k++) @(negedge mclk_i);
        // released line has no pull, so show the inverse rather than a stale bit
        sel_n_o = 1'b1;
        sdi_o   = ~sdi_o;
        @(negedge mclk_i);
    endtask : send
endmodule : rmsr_host_model

// ==== verif/tb_rmsr_ctrl.sv ====
// self-checking bench for the reset mode and software reset controller
`timescale 1ns/1ps

module tb_rmsr_ctrl;
    localparam int SWRST = 100;
    localparam int LIMIT = 20000;

    logic       mclk, rst_n, sck, sdi, sel_n;
    logic       rise_fast, ramp_gap, below_sens, below_norm;
    logic       reset_n, cfg_init, sensitive;
    logic [1:0] cause;
    int         n_mismatch = 0;
    int         comparisons = 0;
    int         cycles = 0;

`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("unexpected %s: expected %h seen %h", nm, exp, got); end end

    rmsr_ctrl #(.SWRST_CYCLES(SWRST)) i_rmsr_ctrl (
        .mclk_i(mclk), .rst_n_i(rst_n), .sck_i(sck), .sdi_i(sdi), .sel_n_i(sel_n),
        .rise_fast_i(rise_fast), .ramp_gap_i(ramp_gap), .below_sens_i(below_sens),
        .below_norm_i(below_norm), .reset_n_o(reset_n), .cfg_init_o(cfg_init),
        .sensitive_o(sensitive), .cause_o(cause));

    rmsr_host_model i_rmsr_host_model (
        .mclk_i(mclk), .reset_n_i(reset_n), .sck_o(sck), .sdi_o(sdi), .sel_n_o(sel_n));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic end_sim();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_mismatch++;
            end_sim();
        end
    end

    task automatic wait_n(input int n);
        repeat (n) @(negedge mclk);
    endtask : wait_n

    // order: rise_fast, ramp_gap, below_sens, below_norm
    task automatic flags(input logic [3:0] f);
        {rise_fast, ramp_gap, below_sens, below_norm} = f;
    endtask : flags

    task automatic t_start();
        `CHK("sensitive", 1'b1, sensitive)
        `CHK("reset_n", 1'b1, reset_n)
        `CHK("cause", 2'h1, cause)
    endtask : t_start

    task automatic t_words();
        i_rmsr_host_model.send(16'hd540, 15, 2, 1'b0);
        wait_n(2);
        `CHK("sensitive", 1'b1, sensitive)
        i_rmsr_host_model.send(16'hd541, 16, 2, 1'b0);
        wait_n(2);
        `CHK("sensitive", 1'b1, sensitive)
        i_rmsr_host_model.send(16'hd540, 16, 5, 1'b0);
        wait_n(2);
        `CHK("sensitive", 1'b0, sensitive)
        i_rmsr_host_model.send(16'hd500, 16, 2, 1'b0);
        wait_n(2);
        `CHK("sensitive", 1'b1, sensitive)
    endtask : t_words

    task automatic t_normal_trips();
        i_rmsr_host_model.send(16'hd540, 16, 2, 1'b0);
        wait_n(2);
        flags(4'b1110);
        wait_n(4);
        `CHK("reset_n", 1'b1, reset_n)
        `CHK("sensitive", 1'b0, sensitive)
        flags(4'b0011);
        wait_n(2);
        `CHK("reset_n", 1'b0, reset_n)
        `CHK("cause", 2'h1, cause)
        flags(4'b0000);
        wait_n(3);
        `CHK("reset_n", 1'b1, reset_n)
        `CHK("sensitive", 1'b1, sensitive)
    endtask : t_normal_trips

    task automatic t_sens_trips();
        flags(4'b1000);
        wait_n(3);
        `CHK("reset_n", 1'b1, reset_n)
        flags(4'b0101);
        wait_n(3);
        `CHK("reset_n", 1'b1, reset_n)
        flags(4'b1100);
        wait_n(2);
        `CHK("reset_n", 1'b0, reset_n)
        flags(4'b0010);
        wait_n(3);
        `CHK("reset_n", 1'b0, reset_n)
        flags(4'b0000);
        wait_n(3);
        `CHK("reset_n", 1'b1, reset_n)
    endtask : t_sens_trips

    task automatic t_soft();
        int lo;
        int ini;
        int g;
        lo = 0;
        ini = 0;
        g = 0;
        i_rmsr_host_model.send(16'hd540, 16, 2, 1'b0);
        i_rmsr_host_model.send(16'hff00, 16, 2, 1'b0);
        wait_n(3);
        `CHK("reset_n", 1'b1, reset_n)
        `CHK("sensitive", 1'b0, sensitive)
        i_rmsr_host_model.send(16'hd500, 16, 2, 1'b0);
        fork
            begin
                i_rmsr_host_model.send(16'hff00, 16, 2, 1'b0);
                while (reset_n !== 1'b0 && g < 20) @(negedge mclk);
                // a word sent in mid-reset must be dropped
                i_rmsr_host_model.send(16'hd540, 16, 2, 1'b1);
            end
            begin
                while (reset_n !== 1'b0 && g < 200) begin
                    g++;
                    @(negedge mclk);
                end
                while (reset_n === 1'b0 && lo < 1000) begin
                    lo++;
                    if (cfg_init === 1'b1) ini++;
                    @(negedge mclk);
                end
            end
        join
        `CHK("soft length", SWRST, lo)
        `CHK("cfg_init pulses", 1, ini)
        `CHK("cause", 2'h2, cause)
        wait_n(3);
        `CHK("sensitive", 1'b1, sensitive)
    endtask : t_soft

    task automatic t_soft_trip();
        i_rmsr_host_model.send(16'hff00, 16, 2, 1'b0);
        `CHK("reset_n", 1'b0, reset_n)
        `CHK("cause", 2'h2, cause)
        flags(4'b0010);
        wait_n(3);
        `CHK("reset_n", 1'b0, reset_n)
        `CHK("cause", 2'h1, cause)
        flags(4'b0000);
        wait_n(3);
        `CHK("reset_n", 1'b1, reset_n)
        `CHK("sensitive", 1'b1, sensitive)
    endtask : t_soft_trip

    task automatic t_rerun();
        i_rmsr_host_model.send(16'hd540, 16, 2, 1'b0);
        wait_n(2);
        `CHK("sensitive", 1'b0, sensitive)
        rst_n = 1'b0;
        wait_n(2);
        `CHK("sensitive", 1'b1, sensitive)
        `CHK("reset_n", 1'b0, reset_n)
        `CHK("cfg_init", 1'b1, cfg_init)
        rst_n = 1'b1;
        wait_n(3);
        `CHK("reset_n", 1'b1, reset_n)
        `CHK("cfg_init", 1'b0, cfg_init)
    endtask : t_rerun

    initial begin
        rst_n = 1'b0;
        flags(4'b0000);
        wait_n(10);
        rst_n = 1'b1;
        wait_n(3);
        t_start();
        t_words();
        t_normal_trips();
        t_sens_trips();
        t_soft();
        t_soft_trip();
        t_rerun();
        end_sim();
    end
endmodule : tb_rmsr_ctrl
